// ---- design/bdsr_pkg.sv ----
// types shared by the bridge status bank
package bdsr_pkg;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
  } bdsr_cmd_t;

  typedef struct packed {
    logic [3:0] pwm_enable;
    logic [3:0] highz;
    logic [3:0] pre_at_limit;
    logic [3:0] chg_at_limit;
    logic [3:0] in_regulation;
  } bdsr_gate_t;

endpackage : bdsr_pkg

// ---- design/bdsr_regs.svh ----
// register offsets, field positions, reset values and frame counts of the bridge status bank
`ifndef BDSR_REGS_SVH
`define BDSR_REGS_SVH

// ----------------------------------------------------------------
// register offsets (7-bit frame address)
// ----------------------------------------------------------------
`define BDSR_OFS_HS_FAULT   7'h46
`define BDSR_OFS_GENERAL_BRIDGE_STATUS   7'h50
`define BDSR_OFS_DELAY_REG  7'h51

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BDSR_HS_OC_LSB      0
`define BDSR_GEN_OUT_LSB    6
`define BDSR_GEN_PWM3_BIT   2
`define BDSR_GEN_PWM1_BIT   0
`define BDSR_DLY_PRE_LSB    8
`define BDSR_DLY_CHG_LSB    4
`define BDSR_DLY_REG_LSB    0
`define BDSR_MODE_ACTIVE    2'h3

// ----------------------------------------------------------------
// reset values and restart masks
// ----------------------------------------------------------------
`define BDSR_RESET_VALUE    16'h0000
`define BDSR_HS_RESTART_CLR 16'hC000
`define BDSR_GEN_RESTART_KP 16'h00C1
`define BDSR_DLY_RESTART_KP 16'h00C1

// ----------------------------------------------------------------
// frame counts
// ----------------------------------------------------------------
`define BDSR_FRAME_BITS     6'd32
`define BDSR_LAST_BIT       6'd31
`define BDSR_CMD_BITS       6'd8
`define BDSR_CMD_LAST       6'd7

`endif

// ---- design/bdsr_status_bank.sv ----
// bridge driver status register bank with its serial frame interface
//
// Function
// - bit 1 of switch fault status latches switch 2 overcurrent, read-to-clear.
// - bit 0 of switch fault status latches switch 1 overcurrent, read-to-clear.
// - soft reset clears switch fault status; restart clears only bits 15:14.
// - general status reserved bits 15:10, 5, 4, 3, 1 read zero.
// - bit 9 shows bridge 4 output high when mode 11 and pump on.
// - bits 8, 7, 6 show bridges 3, 2, 1 output level likewise.
// - output level bit is zero when pump off or mode not 11.
// - bit 2 mirrors the third pwm pin level.
// - bit 0 mirrors the first pwm / crc select pin level.
// - soft reset clears general status; restart keeps bits 7:6 and 0.
// - delay bit 11 is zero when bridge 4 predischarge is clamped.
// - delay bits 10:8 show bridges 3..1 predischarge clamp likewise.
// - delay bit 7 is zero when bridge 4 discharge is clamped.
// - clamp bits read one when pwm off, high impedance or low control setting.
// - delay bits 3:0 are one when that bridge's delay is in regulation.
`include "bdsr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// two-stage synchroniser
// ----------------------------------------------------------------
module bdsr_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // only q leaves this module; meta may still be settling
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : bdsr_sync

// ----------------------------------------------------------------
// status bank top
// ----------------------------------------------------------------
module bdsr_status_bank (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               soft_reset_req,
  input  wire logic               restart_req,
  input  wire logic               charge_pump_enable,
  input  wire logic [7:0]         bridge_mode_field,
  input  wire logic [1:0]         adaptive_gate_control_sel,
  input  wire bdsr_pkg::bdsr_gate_t gate_status,
  input  wire logic [3:0]         bridge_output_sense,
  input  wire logic               third_pwm_pin_level,
  input  wire logic               first_pwm_pin_level,
  input  wire logic [1:0]         switch_overcurrent,
  input  wire logic               spi_sclk,
  input  wire logic               spi_csn,
  input  wire logic               spi_mosi,
  output logic                    spi_miso,
  output logic                    spi_miso_oe_n
);

  // ----------------------------------------------------------------
  // link domain: bit counter and command capture
  // ----------------------------------------------------------------
  // chip select doubles as the link reset, so an aborted frame leaves nothing half counted
  wire logic              link_idle = spi_csn | ~rstn;
  logic [5:0]             bit_cnt;
  logic [7:0]             cmd_shift;
  bdsr_pkg::bdsr_cmd_t    rx_cmd;
  logic                   frame_done;
  logic                   frame_tgl;
  logic [15:0]            rdata;

  // the counter dies with chip select, so no sclk edge is needed to end a frame
  always_ff @(posedge spi_sclk or posedge link_idle) begin
    if (link_idle) begin
      bit_cnt <= 6'h00;
    end else if (bit_cnt != `BDSR_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge spi_sclk or posedge link_idle) begin
    if (link_idle) begin
      cmd_shift <= 8'h00;
    end else if (bit_cnt < `BDSR_CMD_BITS) begin
      cmd_shift <= {cmd_shift[6:0], spi_mosi};
    end
  end

  // command and completion survive chip select so the core can fetch them
  always_ff @(posedge spi_sclk or negedge rstn) begin
    if (!rstn) begin
      rx_cmd     <= '0;
      frame_done <= 1'b0;
      frame_tgl  <= 1'b0;
    end else begin
      if (bit_cnt == `BDSR_CMD_LAST) begin
        rx_cmd <= {cmd_shift[6:0], spi_mosi};
      end
      // set by the 32nd bit, dropped by a 33rd or by the next frame
      frame_done <= (bit_cnt == `BDSR_LAST_BIT);
      // the toggle marks each full frame once, so a chip select pulse without clocks
      // cannot hand the core the previous frame a second time
      if (bit_cnt == `BDSR_LAST_BIT) begin
        frame_tgl <= ~frame_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: answer shifting
  // ----------------------------------------------------------------
  // answer is the previous frame's read data; rdata is quiet during a frame
  // rdata moves about three core cycles after chip select rises: a host that starts
  // the next frame sooner may see a torn answer
  wire logic [31:0] tx_word = {8'h00, rdata, 8'h00};
  wire logic [4:0]  tx_idx  = 5'h1F - bit_cnt[4:0];
  wire logic        tx_bit  = (bit_cnt < `BDSR_FRAME_BITS) ? tx_word[tx_idx] : 1'b0;

  // first bit is a zero status bit, so driving from the first falling edge loses nothing
  always_ff @(negedge spi_sclk or posedge link_idle) begin
    if (link_idle) begin
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso      <= tx_bit;
      spi_miso_oe_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------------
  logic       csn_s;
  logic       csn_q;
  logic       frame_seen;
  logic [7:0] pins_s;

  bdsr_sync #(.W(1), .RST_VAL(1'b1)) u_sync_csn (
    .clk  (clk),
    .rstn (rstn),
    .d    (spi_csn),
    .q    (csn_s)
  );

  bdsr_sync #(.W(8), .RST_VAL(8'h00)) u_sync_pins (
    .clk  (clk),
    .rstn (rstn),
    .d    ({switch_overcurrent, bridge_output_sense, third_pwm_pin_level, first_pwm_pin_level}),
    .q    (pins_s)
  );

  wire logic [1:0] oc_live    = pins_s[7:6];
  wire logic [3:0] sense_live = pins_s[5:2];
  wire logic       pwm3_live  = pins_s[1];
  wire logic       pwm1_live  = pins_s[0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csn_q <= 1'b1;
    end else begin
      csn_q <= csn_s;
    end
  end

  // rx_cmd, frame_done and frame_tgl are stable once chip select has risen
  wire logic frame_end = csn_s & ~csn_q;
  wire logic frame_new = frame_tgl ^ frame_seen;
  wire logic take_read = frame_end & frame_new & frame_done & ~rx_cmd.write;
  wire logic read_hs   = take_read & (rx_cmd.addr == `BDSR_OFS_HS_FAULT);

  // remembers the last frame taken; a cut or empty frame leaves the toggle alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_seen <= 1'b0;
    end else if (frame_end) begin
      frame_seen <= frame_tgl;
    end
  end

  // ----------------------------------------------------------------
  // core domain: live status terms
  // ----------------------------------------------------------------
  logic [3:0] out_level;
  logic [3:0] clamp_bypass;
  logic [3:0] pre_clamp;
  logic [3:0] chg_clamp;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bridge
      assign out_level[gi] = charge_pump_enable &
                             (bridge_mode_field[2*gi +: 2] == `BDSR_MODE_ACTIVE) &
                             sense_live[gi];
      assign clamp_bypass[gi] = ~gate_status.pwm_enable[gi] |
                                gate_status.highz[gi] |
                                ~adaptive_gate_control_sel[1];
      assign pre_clamp[gi] = clamp_bypass[gi] | ~gate_status.pre_at_limit[gi];
      assign chg_clamp[gi] = clamp_bypass[gi] | ~gate_status.chg_at_limit[gi];
    end
  endgenerate

  // output levels and pin mirrors trail their pins by three core cycles
  // reserved bits are tied low by construction
  wire logic [15:0] gen_live = {6'h00,
                                out_level,
                                3'h0,
                                pwm3_live,
                                1'b0,
                                pwm1_live};

  wire logic [15:0] dly_live = {4'h0,
                                pre_clamp,
                                chg_clamp,
                                gate_status.in_regulation};

  // restart leaves the bridge 1 and 2 output levels and the first pin mirror standing for one cycle;
  // afterwards the registers follow their inputs again
  wire logic [15:0] gen_restart = gen_live & `BDSR_GEN_RESTART_KP;
  wire logic [15:0] dly_restart = dly_live & `BDSR_DLY_RESTART_KP;

  // ----------------------------------------------------------------
  // core domain: status registers
  // ----------------------------------------------------------------
  logic [1:0]  oc_flag;
  logic [15:0] general_bridge_status;
  logic [15:0] gate_delay_regulation_status;

  // set wins over the read clear so a persisting fault stays visible
  wire logic [1:0] next_oc_flag = oc_live | (oc_flag & ~{2{read_hs}});

  wire logic [15:0] high_side_switch_fault_status = {14'h0000, oc_flag};

  wire logic [15:0] hs_restart_keep = ~`BDSR_HS_RESTART_CLR;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_flag <= 2'h0;
    end else if (soft_reset_req) begin
      oc_flag <= 2'h0;
    end else if (restart_req) begin
      // restart clears only the top bits, which hold no flag here; events and read
      // clears still count in that cycle so a short fault pulse is not lost
      oc_flag <= next_oc_flag & hs_restart_keep[1:0];
    end else begin
      oc_flag <= next_oc_flag;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_bridge_status        <= `BDSR_RESET_VALUE;
      gate_delay_regulation_status <= `BDSR_RESET_VALUE;
    end else if (soft_reset_req) begin
      general_bridge_status        <= `BDSR_RESET_VALUE;
      gate_delay_regulation_status <= `BDSR_RESET_VALUE;
    end else if (restart_req) begin
      general_bridge_status        <= gen_restart;
      gate_delay_regulation_status <= dly_restart;
    end else begin
      general_bridge_status        <= gen_live;
      gate_delay_regulation_status <= dly_live;
    end
  end

  // ----------------------------------------------------------------
  // core domain: read data for the next answer
  // ----------------------------------------------------------------
  // an unmapped address answers zero rather than the last data
  wire logic hit_hs  = (rx_cmd.addr == `BDSR_OFS_HS_FAULT);
  wire logic hit_gen = (rx_cmd.addr == `BDSR_OFS_GENERAL_BRIDGE_STATUS);
  wire logic hit_dly = (rx_cmd.addr == `BDSR_OFS_DELAY_REG);

  wire logic [15:0] read_mux = hit_hs  ? high_side_switch_fault_status :
                               hit_gen ? general_bridge_status :
                               hit_dly ? gate_delay_regulation_status :
                               16'h0000;

  // writes are ignored: the bank is read only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (take_read) begin
      rdata <= read_mux;
    end
  end

endmodule : bdsr_status_bank

`default_nettype wire

// ---- tb/bdsr_host_model.sv ----
// host model: serial master sending 32-bit mode 0 frames, clock still between frames
`timescale 1ns/100ps
`default_nettype none
module bdsr_host_model (
  output logic      spi_sclk,
  output logic      spi_csn,
  output logic      spi_mosi,
  input  wire logic miso_line
);
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  // odd lead-in keeps link edges off the core clock grid
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    spi_csn = 1'b0;
    #13.7;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      #32 spi_sclk = 1'b1;
      rx = {rx[30:0], miso_line};
      #32 spi_sclk = 1'b0;
    end
    #19.3 spi_csn = 1'b1;
    spi_mosi = ~spi_mosi;
    #60;
  endtask : xfer
  // cut frame: chip select with only a few clock pulses, which the device must ignore
  task automatic stub(input int bits);
    spi_csn = 1'b0;
    #40;
    repeat (bits) begin
      #32 spi_sclk = 1'b1;
      #32 spi_sclk = 1'b0;
    end
    #19.3 spi_csn = 1'b1;
    #60;
  endtask : stub
endmodule : bdsr_host_model
`default_nettype wire

// ---- tb/bdsr_status_bank_sva.sv ----
// checker for the bridge status bank: decodes host frames and judges the answered bits
`timescale 1ns/100ps
`default_nettype none
module bdsr_status_bank_sva (
  input wire logic                 rstn,
  input wire logic                 charge_pump_enable,
  input wire logic [7:0]           bridge_mode_field,
  input wire logic [1:0]           adaptive_gate_control_sel,
  input wire bdsr_pkg::bdsr_gate_t gate_status,
  input wire logic [3:0]           bridge_output_sense,
  input wire logic                 third_pwm_pin_level,
  input wire logic                 first_pwm_pin_level,
  input wire logic [1:0]           switch_overcurrent,
  input wire logic                 spi_sclk,
  input wire logic                 spi_csn,
  input wire logic                 spi_mosi,
  input wire logic                 spi_miso
);
  logic [5:0] n;
  logic [7:0] cmd;
  logic [7:0] prev;
  wire  [5:0] d   = 6'd23 - n;
  wire  [1:0] bo  = 2'(d - 6'd6);
  wire        rhs = prev == 8'hC6;
  wire        rgn = prev == 8'hD0;
  wire        rdl = prev == 8'hD1;
  wire        act = charge_pump_enable && bridge_mode_field[{bo, 1'b0} +: 2] == 2'h3;
  wire  [3:0] liv = gate_status.pwm_enable & ~gate_status.highz & {4{adaptive_gate_control_sel[1]}};
  always_ff @(posedge spi_sclk or posedge spi_csn)
    if (spi_csn) {n, cmd} <= 14'h0000;
    else {n, cmd} <= {n + 6'd1, (n < 6'd8) ? {cmd[6:0], spi_mosi} : cmd};
  // only the frame right after a full read is judged, later answers may be stale
  always_ff @(posedge spi_csn or negedge rstn)
    if (!rstn) prev <= 8'h00;
    else prev <= (n == 6'd32) ? {~cmd[7], cmd[6:0]} : 8'h00;
  default clocking cb @(posedge spi_sclk); endclocking
  default disable iff (!rstn || spi_csn);
  property p_hs_live; rhs && n > 6'd21 && n < 6'd24 && switch_overcurrent[d[0]] |-> spi_miso; endproperty
  a_hs_live: assert property (p_hs_live) else $error("live fault read as clear");
  property p_gen_res; rgn && n > 6'd7 && (d > 6'd9 || d inside {1, 3, 4, 5}) |-> !spi_miso; endproperty
  a_gen_res: assert property (p_gen_res) else $error("reserved bit set");
  property p_out_off; rgn && d inside {[6:9]} && !act |-> !spi_miso; endproperty
  a_out_off: assert property (p_out_off) else $error("output level not forced low");
  property p_out_on; rgn && d inside {[6:9]} && act |-> spi_miso == bridge_output_sense[bo]; endproperty
  a_out_on: assert property (p_out_on) else $error("output level wrong");
  property p_pwm3; rgn && n == 6'd21 |-> spi_miso == third_pwm_pin_level; endproperty
  a_pwm3: assert property (p_pwm3) else $error("third pwm level wrong");
  property p_pwm1; rgn && n == 6'd23 |-> spi_miso == first_pwm_pin_level; endproperty
  a_pwm1: assert property (p_pwm1) else $error("first pwm level wrong");
  property p_pre; rdl && d inside {[8:11]} |-> spi_miso == !(liv[d[1:0]] && gate_status.pre_at_limit[d[1:0]]); endproperty
  a_pre: assert property (p_pre) else $error("predischarge clamp wrong");
  property p_chg; rdl && d inside {[4:7]} |-> spi_miso == !(liv[d[1:0]] && gate_status.chg_at_limit[d[1:0]]); endproperty
  a_chg: assert property (p_chg) else $error("discharge clamp wrong");
  property p_reg; rdl && n > 6'd19 && n < 6'd24 |-> spi_miso == gate_status.in_regulation[d[1:0]]; endproperty
  a_reg: assert property (p_reg) else $error("regulation bit wrong");
endmodule : bdsr_status_bank_sva
bind bdsr_status_bank bdsr_status_bank_sva u_sva (.rstn, .charge_pump_enable, .bridge_mode_field,
  .adaptive_gate_control_sel, .gate_status, .bridge_output_sense, .third_pwm_pin_level,
  .first_pwm_pin_level, .switch_overcurrent, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso);
`default_nettype wire

// ---- tb/bridge_driver_status_regs_bench.sv ----
// self-checking bench for the bridge status bank behind its serial link
`timescale 1ns/100ps
`default_nettype none
module bridge_driver_status_regs_bench;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 soft_reset_req = 1'b0;
  logic                 restart_req = 1'b0;
  logic                 charge_pump_enable = 1'b0;
  logic [7:0]           bridge_mode_field = 8'h00;
  logic [1:0]           adaptive_gate_control_sel = 2'h0;
  bdsr_pkg::bdsr_gate_t gate_status = '0;
  logic [3:0]           bridge_output_sense = 4'h0;
  logic                 third_pwm_pin_level = 1'b0;
  logic                 first_pwm_pin_level = 1'b0;
  logic [1:0]           switch_overcurrent = 2'h0;
  logic [15:0]          rd;
  int                   errors = 0;
  int                   check_count = 0;
  wire                  spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe_n;
  // a released line shows the opposite level so a sample taken outside the drive is caught
  wire                  miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
  always #4 clk = ~clk;
  bdsr_status_bank DUT (.clk, .rstn, .soft_reset_req, .restart_req, .charge_pump_enable, .bridge_mode_field,
    .adaptive_gate_control_sel, .gate_status, .bridge_output_sense, .third_pwm_pin_level, .first_pwm_pin_level,
    .switch_overcurrent, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso, .spi_miso_oe_n);
  bdsr_host_model host (.spi_sclk, .spi_csn, .spi_mosi, .miso_line);
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // answer comes one frame late; a write frame fetches it without clearing again
  task automatic rd_reg(input logic [6:0] addr);
    logic [31:0] rx;
    host.xfer({1'b0, addr, 24'h000000}, rx);
    host.xfer({1'b1, 7'h7F, 24'h000000}, rx);
    rd = rx[23:8];
  endtask : rd_reg
  task automatic fault(input logic [1:0] a, input logic [1:0] b);
    idle(1);
    switch_overcurrent = a;
    idle(10);
    switch_overcurrent = b;
    idle(10);
  endtask : fault
  task automatic t_reset();
    rd_reg(7'h46);
    chk(rd, 16'h0000);
    rd_reg(7'h50);
    chk(rd, 16'h0000);
    rd_reg(7'h51);
    chk(rd, 16'h0FF0);
    rd_reg(7'h10);
    chk(rd, 16'h0000);
    $display("reset values done");
  endtask : t_reset
  task automatic t_oc();
    logic [1:0] st [6] = '{2'h2, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0};
    logic [1:0] hd [6] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};
    logic [1:0] lat = 2'h0;
    for (int i = 0; i < 6; i++) begin
      fault(st[i], hd[i]);
      rd_reg(7'h46);
      lat = lat | st[i] | hd[i];
      chk(rd, {14'h0000, lat});
      lat = hd[i];
    end
    $display("overcurrent done");
  endtask : t_oc
  task automatic t_gen();
    logic [14:0] v [4] = '{{1'b1, 8'hFF, 4'hA, 2'h2}, {1'b1, 8'h3C, 4'hF, 2'h1}, {1'b0, 8'hFF, 4'hF, 2'h3},
                           {1'b1, 8'hC3, 4'h5, 2'h0}};
    logic [3:0] o;
    for (int i = 0; i < 4; i++) begin
      idle(1);
      {charge_pump_enable, bridge_mode_field, bridge_output_sense, third_pwm_pin_level, first_pwm_pin_level} = v[i];
      for (int j = 0; j < 4; j++) o[j] = v[i][14] && v[i][6+2*j +: 2] == 2'h3 && v[i][2+j];
      idle(10);
      rd_reg(7'h50);
      chk(rd, {6'h00, o, 3'h0, v[i][1], 1'b0, v[i][0]});
    end
    $display("general status done");
  endtask : t_gen
  task automatic t_dly();
    logic [21:0] v [4] = '{{2'h2, 16'hF0A5, 4'h9}, {2'h1, 16'hF0FF, 4'h6}, {2'h3, 16'h51FC, 4'hF},
                           {2'h2, 16'h00FF, 4'h0}};
    logic [3:0] l;
    for (int i = 0; i < 4; i++) begin
      idle(1);
      {adaptive_gate_control_sel, gate_status} = v[i];
      l = v[i][19:16] & ~v[i][15:12] & {4{v[i][21]}};
      idle(10);
      rd_reg(7'h51);
      chk(rd, {4'h0, ~(l & v[i][11:8]), ~(l & v[i][7:4]), v[i][3:0]});
    end
    $display("delay status done");
  endtask : t_dly
  task automatic t_rst();
    fault(2'h1, 2'h0);
    restart_req = 1'b1;
    idle(1);
    restart_req = 1'b0;
    rd_reg(7'h46);
    chk(rd, 16'h0001);
    fault(2'h2, 2'h0);
    soft_reset_req = 1'b1;
    idle(1);
    soft_reset_req = 1'b0;
    rd_reg(7'h46);
    chk(rd, 16'h0000);
    $display("reset kinds done");
  endtask : t_rst
  // empty and cut frames must not replay the last read and clear the flags again
  task automatic t_bad();
    logic [31:0] rx;
    fault(2'h1, 2'h0);
    host.xfer({1'b0, 7'h46, 24'h000000}, rx);
    fault(2'h1, 2'h0);
    host.stub(0);
    host.stub(9);
    rd_reg(7'h46);
    chk(rd, 16'h0001);
    $display("cut frames done");
  endtask : t_bad
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    idle(10);
    rstn = 1'b1;
    idle(5);
    t_reset();
    t_oc();
    t_gen();
    t_dly();
    t_rst();
    t_bad();
    summarize();
  end
  // about 45 frames of 2.2 us each plus settling; four times that is a hang
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule : bridge_driver_status_regs_bench
`default_nettype wire
